// ==== ddr2_cmd_regs.svh ====
// Timing counts and field positions for the command and clock-enable link.
// Assumes the system clock also serves as the memory command clock.
`ifndef DDR2_CMD_REGS_SVH
`define DDR2_CMD_REGS_SVH
`define CKE_HOLD_CLKS 2'h3
`define XSRD_CLKS 8'hc8
`define XSNR_CLKS 8'h0a
`define BURST_BEATS 3'h4
`define AP_BIT 4'ha
`define COL_MSB 3'h7
`endif

// ==== ddr2_cmd_pkg.sv ====
// Types shared by the command link ends.
// Assumes the constants header is compiled alongside.
package ddr2_cmd_pkg;
  // Decoded command kinds
  typedef enum logic [3:0] {
    CMD_DESEL, CMD_NOP, CMD_MRS, CMD_REF, CMD_SREF_IN, CMD_PRE,
    CMD_PREALL, CMD_ACT, CMD_WR, CMD_RD, CMD_PD_IN, CMD_EXIT, CMD_BAD
  } cmd_t;
  // Device power states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ACTIVE, ST_APD, ST_PPD, ST_SREF
  } pstate_t;
endpackage : ddr2_cmd_pkg

// ==== ddr2_cmd_if.sv ====
// Command link between controller and memory device.
// Assumes both ends share clk_sys_i; cs_n, ras_n, cas_n and we_n are active low, the rest active high.
`timescale 1ns/1ps
interface ddr2_cmd_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [12:0] addr;
  logic odt;
  logic [31:0] dq;
  logic [3:0] dm;
  logic dq_valid;
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dq, dm,
    dq_valid);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dq, dm,
    dq_valid);
endinterface : ddr2_cmd_if

// ==== ddr2_ctrl_end.sv ====
// Controller end: turns user requests into link commands; self refresh goes out even with a bank open.
// Assumes the user waits for req_ready_o before offering a request.
`timescale 1ns/1ps
`include "ddr2_cmd_regs.svh"

module ddr2_ctrl_end (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  ddr2_cmd_if.ctrl link,
  input wire logic req_valid_i,
  input wire ddr2_cmd_pkg::cmd_t req_cmd_i,
  input wire logic [1:0] req_ba_i,
  input wire logic [12:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic [3:0] req_wmask_i,
  input wire logic odt_i,
  output logic req_ready_o
);
  // All controller state
  typedef struct packed {
    logic cke;
    logic cs_n, ras_n, cas_n, we_n;
    logic [1:0] ba;
    logic [12:0] addr;
    logic odt;
    logic [31:0] dq;
    logic [3:0] dm;
    logic dv;
    logic [1:0] hold;   // CKE hold count
    logic [2:0] burst;  // Burst beats left
    logic [7:0] wait_c; // Exit delay count
    logic lowpow;       // CKE low state
    logic ready;
  } cstate_t;
  cstate_t s, next_s;

  // Command drive and duty timing
  always_comb begin
    next_s = s;
    // Default every edge to NOP with defined levels
    {next_s.cs_n, next_s.ras_n, next_s.cas_n, next_s.we_n} = 4'h7;
    next_s.ba = 2'h0;
    next_s.addr = 13'h0000;
    next_s.dv = 1'b0;
    next_s.dm = 4'hf;
    next_s.odt = odt_i; // Always defined, also in power-down
    if (s.hold != 2'h0) next_s.hold = s.hold - 2'h1;
    if (s.burst != 3'h0) begin // Never cut a burst short
      next_s.burst = s.burst - 3'h1;
      next_s.dv = s.dv;
      next_s.dm = s.dm;
      next_s.dq = s.dq;
    end
    if (s.wait_c != 8'h00) next_s.wait_c = s.wait_c - 8'h01;
    if (req_valid_i && s.ready) begin
      unique case (req_cmd_i)
        ddr2_cmd_pkg::CMD_PD_IN, ddr2_cmd_pkg::CMD_SREF_IN: begin
          // CKE falls with NOP or REF only, no burst running
          next_s.cke = 1'b0;
          next_s.lowpow = 1'b1;
          next_s.hold = `CKE_HOLD_CLKS;
          if (req_cmd_i == ddr2_cmd_pkg::CMD_SREF_IN) begin
            {next_s.cs_n, next_s.ras_n, next_s.cas_n} = 3'h0;
          end
        end
        ddr2_cmd_pkg::CMD_EXIT: begin
          next_s.cke = 1'b1; // NOP on the rising edge
          next_s.lowpow = 1'b0;
          next_s.hold = `CKE_HOLD_CLKS;
          next_s.wait_c = `XSRD_CLKS; // Conservative for all exits
        end
        ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::CMD_REF: begin
          {next_s.cs_n, next_s.ras_n, next_s.cas_n} = 3'h0;
          next_s.we_n = (req_cmd_i == ddr2_cmd_pkg::CMD_REF);
          next_s.ba = req_ba_i;
          next_s.addr = req_addr_i;
        end
        ddr2_cmd_pkg::CMD_PRE, ddr2_cmd_pkg::CMD_PREALL,
        ddr2_cmd_pkg::CMD_ACT: begin
          {next_s.cs_n, next_s.ras_n, next_s.cas_n} = 3'h1;
          next_s.we_n = (req_cmd_i == ddr2_cmd_pkg::CMD_ACT);
          next_s.ba = req_ba_i;
          next_s.addr = req_addr_i;
          if (req_cmd_i == ddr2_cmd_pkg::CMD_PREALL)
            next_s.addr[`AP_BIT] = 1'b1;
        end
        ddr2_cmd_pkg::CMD_WR, ddr2_cmd_pkg::CMD_RD: begin
          {next_s.cs_n, next_s.ras_n, next_s.cas_n} = 3'h2;
          next_s.we_n = (req_cmd_i == ddr2_cmd_pkg::CMD_RD);
          next_s.ba = req_ba_i;
          next_s.addr = req_addr_i;
          next_s.burst = `BURST_BEATS;
          next_s.dv = (req_cmd_i == ddr2_cmd_pkg::CMD_WR);
          next_s.dq = req_wdata_i;
          next_s.dm = req_wmask_i;
        end
        default: begin
          // NOP and anything untabled go out as NOP
        end
      endcase
    end
    // Accept only when no burst, hold or exit delay is running
    next_s.ready = (next_s.burst == 3'h0) && (next_s.hold == 2'h0) &&
      (next_s.wait_c == 8'h00);
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.cke <= 1'b1; // Running, not in power-down
      s.cs_n <= 1'b1;
      s.ras_n <= 1'b1;
      s.cas_n <= 1'b1;
      s.we_n <= 1'b1;
      s.dm <= 4'hf;
    end else begin
      s <= next_s;
    end
  end

  assign link.cke = s.cke;
  assign link.cs_n = s.cs_n;
  assign link.ras_n = s.ras_n;
  assign link.cas_n = s.cas_n;
  assign link.we_n = s.we_n;
  assign link.ba = s.ba;
  assign link.addr = s.addr;
  assign link.odt = s.odt;
  assign link.dq = s.dq;
  assign link.dm = s.dm;
  assign link.dq_valid = s.dv;
  assign req_ready_o = s.ready;
endmodule : ddr2_ctrl_end

// ==== ddr2_dev_end.sv ====
// Device end: decodes link commands and tracks clock-enable power state.
// Assumes controller keeps the far-side duties; write data uses the link.
`timescale 1ns/1ps
`include "ddr2_cmd_regs.svh"

module ddr2_dev_end (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  ddr2_cmd_if.dev link,
  output ddr2_cmd_pkg::cmd_t cmd_o,
  output logic [1:0] cmd_ba_o,
  output logic [12:0] cmd_addr_o,
  output logic cmd_ap_o,
  output ddr2_cmd_pkg::pstate_t pstate_o,
  output logic [3:0] bank_open_o,
  output logic odt_on_o,
  output logic burst_busy_o,
  output logic refresh_ok_o,
  output logic [31:0] wdata_o,
  output logic [3:0] wbyte_en_o,
  output logic wr_o,
  output logic illegal_o
);
  // All device state except the async CKE capture flop
  typedef struct packed {
    logic cke_prev;
    ddr2_cmd_pkg::cmd_t cmd;
    logic [1:0] ba;
    logic [12:0] addr;
    logic ap;
    ddr2_cmd_pkg::pstate_t ps;
    logic [3:0] open;
    logic odt_on;
    logic [2:0] burst;
    logic busy;         // Burst running, kept in a flop for a clean output
    logic refresh_ok;
    logic [31:0] wdata;
    logic [3:0] wen;
    logic wr;
    logic bad;
  } dstate_t;
  dstate_t s, next_s;
  logic cke_async_q; // Async capture of CKE rise

  // Command table lookup
  // Inputs: clock enable of the last edge, clock enable now, the four
  // command pins with chip select on top, and the auto precharge bit.
  // Anything the tables do not list comes back as a bad command, so the
  // caller only needs one compare to raise the illegal flag.
  // Pure function, no state; used once per edge by the decode process.
  function automatic ddr2_cmd_pkg::cmd_t decode(input logic cp,
    input logic cc, input logic [3:0] c, input logic a10);
    decode = ddr2_cmd_pkg::CMD_BAD;
    if (cp && cc) begin
      if (c[3]) decode = ddr2_cmd_pkg::CMD_DESEL;
      else unique case (c[2:0])
        3'h7: decode = ddr2_cmd_pkg::CMD_NOP;
        3'h0: decode = ddr2_cmd_pkg::CMD_MRS;
        3'h1: decode = ddr2_cmd_pkg::CMD_REF;
        3'h3: decode = ddr2_cmd_pkg::CMD_ACT;
        3'h2: decode = a10 ? ddr2_cmd_pkg::CMD_PREALL :
          ddr2_cmd_pkg::CMD_PRE;
        3'h4: decode = ddr2_cmd_pkg::CMD_WR;
        3'h5: decode = ddr2_cmd_pkg::CMD_RD;
        default: decode = ddr2_cmd_pkg::CMD_BAD;
      endcase
    end else if (cp && !cc) begin
      if (!c[3] && c[2:0] == 3'h1) decode = ddr2_cmd_pkg::CMD_SREF_IN;
      else if (c[3] || c[2:0] == 3'h7) decode = ddr2_cmd_pkg::CMD_PD_IN;
    end else if (!cp && cc) begin
      if (c[3] || c[2:0] == 3'h7) decode = ddr2_cmd_pkg::CMD_EXIT;
    end else begin
      decode = ddr2_cmd_pkg::CMD_DESEL; // Maintain low power
    end
  endfunction : decode

  // CKE rise latched with no clock edge needed
  // Limitation: this flop is only cleared by reset, so after the first
  // rise it stays set; the exit test below therefore also demands that
  // the clock enable pin is high now, which keeps later entries correct.
  // Trade-off: a second clock domain of one flop; the state machine still
  // leaves self refresh only at a clk_sys_i edge, never with the command clock stopped.
  always_ff @(posedge link.cke or negedge resetn_i) begin
    if (!resetn_i) cke_async_q <= 1'b0;
    else cke_async_q <= 1'b1;
  end

  // Decode and power state; ODT never enters the decode
  always_comb begin
    ddr2_cmd_pkg::cmd_t c;
    logic cur;
    c = decode(s.cke_prev, link.cke,
      {link.cs_n, link.ras_n, link.cas_n, link.we_n},
      link.addr[`AP_BIT]);
    cur = link.cke;
    next_s = s;
    next_s.cke_prev = cur;
    next_s.cmd = c;
    next_s.ba = link.ba;
    next_s.addr = link.addr;
    next_s.ap = link.addr[`AP_BIT];
    next_s.wr = 1'b0;
    next_s.bad = (c == ddr2_cmd_pkg::CMD_BAD);
    if (s.burst != 3'h0) next_s.burst = s.burst - 3'h1;
    unique case (c)
      ddr2_cmd_pkg::CMD_ACT: next_s.open[link.ba] = 1'b1;
      ddr2_cmd_pkg::CMD_PRE: next_s.open[link.ba] = 1'b0;
      ddr2_cmd_pkg::CMD_PREALL: next_s.open = 4'h0;
      ddr2_cmd_pkg::CMD_WR, ddr2_cmd_pkg::CMD_RD: begin
        next_s.bad = (s.burst != 3'h0); // Interrupting a burst
        if (s.burst == 3'h0) next_s.burst = `BURST_BEATS;
      end
      ddr2_cmd_pkg::CMD_PD_IN:
        next_s.ps = (s.open != 4'h0) ? ddr2_cmd_pkg::ST_APD :
          ddr2_cmd_pkg::ST_PPD;
      ddr2_cmd_pkg::CMD_SREF_IN: begin
        next_s.bad = (s.open != 4'h0);
        next_s.ps = ddr2_cmd_pkg::ST_SREF;
      end
      ddr2_cmd_pkg::CMD_EXIT: // Also from async capture
        next_s.ps = (s.open != 4'h0) ? ddr2_cmd_pkg::ST_ACTIVE :
          ddr2_cmd_pkg::ST_IDLE;
      default: begin
        if (s.ps != ddr2_cmd_pkg::ST_SREF && s.ps != ddr2_cmd_pkg::ST_APD &&
          s.ps != ddr2_cmd_pkg::ST_PPD)
          next_s.ps = (next_s.open != 4'h0) ? ddr2_cmd_pkg::ST_ACTIVE :
            ddr2_cmd_pkg::ST_IDLE;
      end
    endcase
    // Self refresh left at the next clk_sys_i edge after a latched CKE rise while CKE is still high
    if (s.ps == ddr2_cmd_pkg::ST_SREF && cke_async_q && cur)
      next_s.ps = ddr2_cmd_pkg::ST_IDLE;
    // Internal refresh only in self refresh, never power-down
    next_s.refresh_ok = (next_s.ps == ddr2_cmd_pkg::ST_SREF);
    // Busy flag registered from the new count, so it matches the count
    next_s.busy = (next_s.burst != 3'h0);
    // Termination follows its pin, except while self refreshing
    next_s.odt_on = link.odt && (next_s.ps != ddr2_cmd_pkg::ST_SREF);
    // Beat write: byte enable is the inverse of its mask
    // A beat is stored on the same edge at which its mask is registered;
    // the data word passes unchanged, the enables decide what lands.
    next_s.wr = link.dq_valid;
    next_s.wdata = link.dq;
    next_s.wen = link.dq_valid ? ~link.dm : 4'h0;
  end

  // State register
  // Reset leaves the device idle with the clock enable taken as high,
  // so the first edge after release is decoded as a normal command
  // and never as a false power-down exit.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.cke_prev <= 1'b1;
      s.cmd <= ddr2_cmd_pkg::CMD_DESEL;
      s.ps <= ddr2_cmd_pkg::ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Every output below is a plain copy of a state flop
  // No logic sits between the register and the pins of this end
  assign cmd_o = s.cmd;
  assign cmd_ba_o = s.ba;
  assign cmd_addr_o = s.addr;
  assign cmd_ap_o = s.ap;
  assign pstate_o = s.ps;
  assign bank_open_o = s.open;
  assign odt_on_o = s.odt_on;
  assign burst_busy_o = s.busy;
  assign refresh_ok_o = s.refresh_ok;
  assign wdata_o = s.wdata;
  assign wbyte_en_o = s.wen;
  assign wr_o = s.wr;
  assign illegal_o = s.bad;
endmodule : ddr2_dev_end

// ==== ddr2_link_chk.sv ====
// Checker for the command link and the device end's decoded outputs.
// Assumes one clock domain; link signals and outputs are wired by name.
`timescale 1ns/1ps
module ddr2_link_chk (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [3:0] dm,
  input wire logic dq_valid,
  input wire ddr2_cmd_pkg::cmd_t cmd_o,
  input wire ddr2_cmd_pkg::pstate_t pstate_o,
  input wire logic [3:0] bank_open_o,
  input wire logic [3:0] wbyte_en_o,
  input wire logic odt_on_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // Command pins as one nibble, cs_n on top
  logic [3:0] c;
  // Any bank open decides the power-down flavour
  logic any_open;
  assign c = {cs_n, ras_n, cas_n, we_n};
  assign any_open = |bank_open_o;
  AST_MRS: assert property (
    cke && $past(cke) && c == 4'h0 |=> cmd_o == ddr2_cmd_pkg::CMD_MRS)
    else $error("mode set not decoded");
  AST_ACT: assert property (
    cke && $past(cke) && c == 4'h3 |=> cmd_o == ddr2_cmd_pkg::CMD_ACT)
    else $error("activate not decoded");
  AST_WR: assert property (
    cke && $past(cke) && c == 4'h4 |=> cmd_o == ddr2_cmd_pkg::CMD_WR)
    else $error("write not decoded");
  AST_RD: assert property (
    cke && $past(cke) && c == 4'h5 |=> cmd_o == ddr2_cmd_pkg::CMD_RD)
    else $error("read not decoded");
  AST_NOP: assert property (
    cke && $past(cke) && c == 4'h7 |=> cmd_o == ddr2_cmd_pkg::CMD_NOP)
    else $error("no-op not decoded");
  // Flavour is taken from the banks as they stood at the falling edge
  AST_PD_IN: assert property (
    $past(cke) && !cke && (cs_n || c == 4'h7) |=> pstate_o ==
    ($past(any_open) ? ddr2_cmd_pkg::ST_APD : ddr2_cmd_pkg::ST_PPD))
    else $error("power-down entry wrong");
  AST_SREF_IN: assert property (
    $past(cke) && !cke && c == 4'h1 |=> pstate_o == ddr2_cmd_pkg::ST_SREF)
    else $error("self refresh entry missed");
  AST_SREF_OUT: assert property (
    pstate_o == ddr2_cmd_pkg::ST_SREF && cke
    |=> pstate_o != ddr2_cmd_pkg::ST_SREF)
    else $error("self refresh exit missed");
  AST_ODT_OFF: assert property (
    pstate_o == ddr2_cmd_pkg::ST_SREF |-> !odt_on_o)
    else $error("termination on in self refresh");
  AST_MASK: assert property (
    dq_valid |=> wbyte_en_o == ~$past(dm))
    else $error("byte enables not inverse of mask");
  // Main scenarios reached
  cover property (pstate_o == ddr2_cmd_pkg::ST_APD);
  cover property (pstate_o == ddr2_cmd_pkg::ST_SREF);
  cover property (cmd_o == ddr2_cmd_pkg::CMD_WR);
endmodule : ddr2_link_chk

// ==== ddr2_command_and_cke_decoder_tb.sv ====
// Bench joining controller and device ends over the command link.
// Assumes a 250 MHz clock and the controller's ready handshake.
`timescale 1ns/1ps
module ddr2_command_and_cke_decoder_tb;
  // One table row: request and the bank map it should leave
  typedef struct {
    ddr2_cmd_pkg::cmd_t cmd;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [3:0] open;
  } row_t;
  logic clk_sys_i, resetn_i, req_valid_i, odt_i, req_ready_o;
  ddr2_cmd_pkg::cmd_t req_cmd_i, cmd_o;
  ddr2_cmd_pkg::pstate_t pstate_o;
  logic [1:0] req_ba_i, cmd_ba_o;
  logic [12:0] req_addr_i, cmd_addr_o;
  logic [31:0] req_wdata_i, wdata_o;
  logic [3:0] req_wmask_i, bank_open_o, wbyte_en_o;
  logic cmd_ap_o, odt_on_o, burst_busy_o, refresh_ok_o, wr_o, illegal_o;
  int n_mismatch = 0;
  int n_checks = 0;
  int n;
  logic [3:0] lk; // Link command pins as the bench sees them
  row_t rows[9];
  ddr2_cmd_if i_ddr2_cmd_if ();
  ddr2_ctrl_end i_ddr2_ctrl_end (.clk_sys_i, .resetn_i,
    .link(i_ddr2_cmd_if.ctrl), .req_valid_i, .req_cmd_i, .req_ba_i,
    .req_addr_i, .req_wdata_i, .req_wmask_i, .odt_i, .req_ready_o);
  ddr2_dev_end i_ddr2_dev_end (.clk_sys_i, .resetn_i,
    .link(i_ddr2_cmd_if.dev), .cmd_o, .cmd_ba_o, .cmd_addr_o, .cmd_ap_o,
    .pstate_o, .bank_open_o, .odt_on_o, .burst_busy_o, .refresh_ok_o,
    .wdata_o, .wbyte_en_o, .wr_o, .illegal_o);
  ddr2_link_chk i_ddr2_link_chk (.clk_sys_i, .resetn_i,
    .cke(i_ddr2_cmd_if.cke), .cs_n(i_ddr2_cmd_if.cs_n),
    .ras_n(i_ddr2_cmd_if.ras_n), .cas_n(i_ddr2_cmd_if.cas_n),
    .we_n(i_ddr2_cmd_if.we_n), .dm(i_ddr2_cmd_if.dm),
    .dq_valid(i_ddr2_cmd_if.dq_valid), .cmd_o, .pstate_o, .bank_open_o,
    .wbyte_en_o, .odt_on_o);
  // Free-running system clock, 4 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // Compare and count; four-state so unknowns never match
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Move just past a rising edge, where inputs change
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : step
  // Wait for ready, hold the request over one edge; ends when decoded
  task automatic req(input ddr2_cmd_pkg::cmd_t c, input logic [1:0] b,
      input logic [12:0] a);
    while (req_ready_o !== 1'b1) begin
      step(1);
    end
    req_cmd_i = c;
    req_ba_i = b;
    req_addr_i = a;
    req_valid_i = 1'b1;
    step(1);
    req_valid_i = 1'b0;
    step(1);
  endtask : req
  // Single verdict point for normal end and watchdog
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  // Watchdog: three exits of 200 cycles plus traffic fit well inside
  initial begin
    repeat (4000) @(posedge clk_sys_i);
    n_mismatch++;
    stop_test();
  end
  initial begin
    resetn_i = 1'b0;
    req_valid_i = 1'b0;
    req_cmd_i = ddr2_cmd_pkg::CMD_NOP;
    req_ba_i = 2'h0;
    req_addr_i = 13'h0000;
    req_wdata_i = 32'h1234abcd;
    req_wmask_i = 4'h5;
    odt_i = 1'b0;
    rows = '{'{ddr2_cmd_pkg::CMD_NOP, 2'h0, 13'h0000, 4'h0},
      '{ddr2_cmd_pkg::CMD_MRS, 2'h2, 13'h0123, 4'h0},
      '{ddr2_cmd_pkg::CMD_ACT, 2'h1, 13'h0abc, 4'h2},
      '{ddr2_cmd_pkg::CMD_ACT, 2'h2, 13'h0111, 4'h6},
      '{ddr2_cmd_pkg::CMD_PRE, 2'h2, 13'h0000, 4'h2},
      '{ddr2_cmd_pkg::CMD_WR, 2'h1, 13'h00a5, 4'h2},
      '{ddr2_cmd_pkg::CMD_RD, 2'h1, 13'h043c, 4'h2},
      '{ddr2_cmd_pkg::CMD_PREALL, 2'h0, 13'h0400, 4'h0},
      '{ddr2_cmd_pkg::CMD_REF, 2'h0, 13'h0000, 4'h0}};
    step(4);
    chk("rst_ps", 32'(pstate_o), 32'(ddr2_cmd_pkg::ST_IDLE));
    chk("rst_cke", 32'(i_ddr2_cmd_if.cke), 32'h1);
    resetn_i = 1'b1;
    // Ordinary commands from the table
    foreach (rows[i]) begin
      req(rows[i].cmd, rows[i].ba, rows[i].addr);
      chk("cmd", 32'(cmd_o), 32'(rows[i].cmd));
      chk("legal", 32'(illegal_o), 32'h0);
      if (rows[i].cmd inside {ddr2_cmd_pkg::CMD_WR, ddr2_cmd_pkg::CMD_RD}) begin
        chk("col", 32'(cmd_addr_o[7:0]), 32'(rows[i].addr[7:0]));
        chk("ap", 32'(cmd_ap_o), 32'(rows[i].addr[10]));
        chk("ba", 32'(cmd_ba_o), 32'(rows[i].ba));
      end else begin
        chk("open", 32'(bank_open_o), 32'(rows[i].open));
      end
      if (rows[i].cmd == ddr2_cmd_pkg::CMD_WR) begin
        chk("wdata", wdata_o, 32'h1234abcd);
        chk("ben", 32'(wbyte_en_o), 32'ha);
        chk("wr", 32'(wr_o), 32'h1);
        chk("busy", 32'(burst_busy_o), 32'h1);
      end
    end
    // Power-down with a bank open, then with all idle
    req(ddr2_cmd_pkg::CMD_ACT, 2'h0, 13'h0010);
    req(ddr2_cmd_pkg::CMD_PD_IN, 2'h0, 13'h0000);
    chk("cke_pd", 32'(i_ddr2_cmd_if.cke), 32'h0);
    step(5);
    chk("apd", 32'(pstate_o), 32'(ddr2_cmd_pkg::ST_APD));
    chk("no_ref", 32'(refresh_ok_o), 32'h0);
    req(ddr2_cmd_pkg::CMD_EXIT, 2'h0, 13'h0000);
    req(ddr2_cmd_pkg::CMD_PREALL, 2'h0, 13'h0400);
    req(ddr2_cmd_pkg::CMD_PD_IN, 2'h0, 13'h0000);
    chk("ppd", 32'(pstate_o), 32'(ddr2_cmd_pkg::ST_PPD));
    req(ddr2_cmd_pkg::CMD_EXIT, 2'h0, 13'h0000);
    chk("pd_out", 32'(pstate_o), 32'(ddr2_cmd_pkg::ST_IDLE));
    // Self refresh with termination requested; it must drop
    odt_i = 1'b1;
    req(ddr2_cmd_pkg::CMD_SREF_IN, 2'h0, 13'h0000);
    chk("sref", 32'(pstate_o), 32'(ddr2_cmd_pkg::ST_SREF));
    chk("odt", 32'(odt_on_o), 32'h0);
    chk("ref_ok", 32'(refresh_ok_o), 32'h1);
    req(ddr2_cmd_pkg::CMD_EXIT, 2'h0, 13'h0000);
    chk("sr_out", 32'(pstate_o), 32'(ddr2_cmd_pkg::ST_IDLE));
    // Count the refused span; link must idle throughout
    n = 0;
    while (req_ready_o !== 1'b1 && n < 300) begin
      lk = {i_ddr2_cmd_if.cs_n, i_ddr2_cmd_if.ras_n, i_ddr2_cmd_if.cas_n,
        i_ddr2_cmd_if.we_n};
      chk("xsnr_nop", 32'(lk), 32'h7);
      step(1);
      n++;
    end
    chk("xsrd", 32'(n >= 190 && n < 300), 32'h1);
    chk("odt_on", 32'(odt_on_o), 32'h1);
    // Reset in mid-run with a bank open
    req(ddr2_cmd_pkg::CMD_ACT, 2'h3, 13'h0020);
    // Self refresh with a bank still open is flagged by the device
    req(ddr2_cmd_pkg::CMD_SREF_IN, 2'h0, 13'h0000);
    chk("sref_open", 32'(illegal_o), 32'h1);
    resetn_i = 1'b0;
    step(1);
    chk("rst_open", 32'(bank_open_o), 32'h0);
    chk("rst_ps2", 32'(pstate_o), 32'(ddr2_cmd_pkg::ST_IDLE));
    resetn_i = 1'b1;
    step(2);
    stop_test();
  end
endmodule : ddr2_command_and_cke_decoder_tb
